// >>> pkg/pdrc_pkg.sv
// ****************************************************************
// Power-down, reference and reset control constants
// ****************************************************************
package pdrc_pkg;

  // ****************************************************************
  // Register pointers and reset key
  // ****************************************************************
  localparam logic [7:0]  PTR_PD_REF   = 8'h0B;   // Power-down and reference control
  localparam logic [7:0]  PTR_SW_RESET = 8'h0F;   // Software reset key register
  localparam logic [15:0] RESET_KEY    = 16'h0DAC; // Value that fires the full reset

  // ****************************************************************
  // Field layout of the power-down and reference control register
  // ****************************************************************
  localparam int          GPD_BIT      = 10;      // Global power-down
  localparam int          REF_BIT      = 9;       // Reference and buffer enable
  localparam int          CH_MSB       = 7;       // Top channel power-down bit
  localparam logic [10:0] PD_REG_RESET = 11'h000; // Value after reset
  localparam logic [4:0]  PD_RSVD_READ = 5'h00;   // Upper bits read back as zero

  // ****************************************************************
  // Serial link constants
  // ****************************************************************
  localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h11; // Slave address, arbitrary value
  localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;  // Bits in one byte

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ      = 50_000_000;                        // Core clock rate
  localparam int RST_TIME_US = 100;                               // Reset duration
  localparam int RST_CYCLES  = (CLK_HZ / 1_000_000) * RST_TIME_US; // Longest time, rounded down

  // ****************************************************************
  // Serial link states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,  // No transfer
    ST_RX,    // Receiving a byte
    ST_ACK,   // Driving acknowledge
    ST_TX,    // Sending a byte
    ST_RACK,  // Sampling host acknowledge
    ST_WAIT   // Ignore until stop or start
  } pdrc_state_e;

endpackage

// >>> design/pdrc_rst_timer.sv
`timescale 1ns/1ps
// ****************************************************************
// Reset interval timer
// ****************************************************************
module pdrc_rst_timer #(
  parameter int unsigned CYCLES = pdrc_pkg::RST_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy
);

  logic [15:0] cnt;        // Cycles left in the interval
  logic [15:0] next_cnt;   // Next count
  logic        next_busy;  // Next busy

  // Load on start, count down while busy
  always_comb begin
    next_cnt  = cnt;
    next_busy = busy;
    if (start) begin
      next_busy = 1'b1;
      next_cnt  = 16'(CYCLES - 1);
    end else if (busy) begin
      if (cnt == 16'h0000) begin
        next_busy = 1'b0;
      end else begin
        next_cnt = cnt - 16'h0001;
      end
    end
  end

  // Register the timer state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt  <= 16'h0000;
      busy <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      busy <= next_busy;
    end
  end

endmodule // pdrc_rst_timer

// >>> design/pdrc_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Pointer 0x0B selects power-down/reference register
// - Channel bit powers down only DAC channels
// - Powered-down DAC output driver goes high-impedance
// - Leaving power-down restores previous DAC value
// - Reference enable defaults off, set powers up
// - ADC off when no pin is ADC and no temperature read is active
// - Temperature read powers ADC up
// - Global power-down overrides all other bits
// - Key 0x0DAC at 0x0F resets everything
// - Reset fires on last bit, no acknowledge
// - Reset pin falling edge does same reset
// - Pins return to default pull-down on reset
module pdrc_ctrl #(
  parameter logic [6:0]  DEV_ADDR   = pdrc_pkg::DEV_ADDR_DEFAULT,
  parameter int unsigned RST_CYCLES = pdrc_pkg::RST_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scl,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       reset_pin_n,
  input  wire logic [7:0] dac_config,
  input  wire logic [7:0] adc_config,
  input  wire logic       temp_read_active,
  output logic [7:0]      dac_output_enable,
  output logic [7:0]      dac_channel_power_down,
  output logic            ref_enable,
  output logic            adc_power,
  output logic            config_reset
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  pdrc_pkg::pdrc_state_e state, next_state; // Serial link state
  logic [3:0]  bit_cnt, next_bit_cnt;       // Bit within byte
  logic [7:0]  shreg, next_shreg;           // Receive shifter
  logic [1:0]  byte_idx, next_byte_idx;     // 0 addr, 1 pointer, 2 msb, 3 lsb
  logic        rw, next_rw;                 // Read transfer
  logic        rd_sel, next_rd_sel;         // 0 sends msb, 1 lsb
  logic [7:0]  pointer, next_pointer;       // Selected register
  logic [7:0]  msb, next_msb;               // Pending high byte
  logic        next_sda_oe;                 // Next data drive
  logic [10:0] pd_reg, next_pd_reg;         // Power-down and reference control
  logic        scl_q, sda_q, pin_q;         // Previous pin levels
  logic        scl_rise, scl_fall;          // Clock edges
  logic        start_c, stop_c;             // Bus conditions
  logic        sw_trig;                     // Keyed write seen
  logic        wr_strobe;                   // Register write
  logic        pin_fall;                    // Reset pin edge
  logic        busy;                        // Reset interval running
  logic        gpd;                         // Global power-down
  logic [15:0] rd_word;                     // Read-back data
  logic [7:0]  tx_byte, tx_next;            // Current and next send byte

  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_c  = scl & scl_q & sda_q & ~sda_i;
  assign stop_c   = scl & scl_q & ~sda_q & sda_i;
  assign pin_fall = pin_q & ~reset_pin_n;
  assign gpd      = pd_reg[pdrc_pkg::GPD_BIT];
  // Reserved upper bits are not stored, always read back as zero
  assign rd_word  = (pointer == pdrc_pkg::PTR_PD_REF) ? {pdrc_pkg::PD_RSVD_READ, pd_reg}
                                                      : 16'h0000;
  assign tx_byte  = rd_sel ? rd_word[7:0] : rd_word[15:8];
  assign tx_next  = rd_sel ? rd_word[15:8] : rd_word[7:0];

  // ****************************************************************
  // Reset interval
  // ****************************************************************
  // Keyed write or pin edge starts the interval
  pdrc_rst_timer #(
    .CYCLES (RST_CYCLES)
  ) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .start (sw_trig | pin_fall),
    .busy  (busy)
  );

  // ****************************************************************
  // Serial link next state
  // ****************************************************************
  // Byte engine, decode and register write
  always_comb begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_byte_idx = byte_idx;
    next_rw       = rw;
    next_rd_sel   = rd_sel;
    next_pointer  = pointer;
    next_msb      = msb;
    next_sda_oe   = sda_oe;
    sw_trig       = 1'b0;
    wr_strobe     = 1'b0;
    if (start_c) begin
      // Start or repeated start
      next_state    = pdrc_pkg::ST_RX;
      next_bit_cnt  = 4'h0;
      next_byte_idx = 2'h0;
      next_sda_oe   = 1'b0;
    end else if (stop_c) begin
      // Stop ends any transfer
      next_state  = pdrc_pkg::ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        pdrc_pkg::ST_RX: begin
          if (scl_rise) begin
            next_shreg   = {shreg[6:0], sda_i};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == pdrc_pkg::BITS_PER_BYTE) begin
            next_bit_cnt = 4'h0;
            next_state   = pdrc_pkg::ST_ACK;
            next_sda_oe  = 1'b1;
            if (busy) begin
              // No acknowledge during reset
              next_state  = pdrc_pkg::ST_WAIT;
              next_sda_oe = 1'b0;
            end else begin
              case (byte_idx)
                2'h0: begin
                  if (shreg[7:1] == DEV_ADDR) begin
                    next_rw       = shreg[0];
                    next_rd_sel   = 1'b0;
                    next_byte_idx = shreg[0] ? 2'h0 : 2'h1;
                  end else begin
                    next_state  = pdrc_pkg::ST_WAIT;
                    next_sda_oe = 1'b0;
                  end
                end
                2'h1: begin
                  next_pointer  = shreg;
                  next_byte_idx = 2'h2;
                end
                2'h2: begin
                  next_msb      = shreg;
                  next_byte_idx = 2'h3;
                end
                default: begin
                  next_byte_idx = 2'h2;
                  if (pointer == pdrc_pkg::PTR_SW_RESET && {msb, shreg} == pdrc_pkg::RESET_KEY) begin
                    // Fire on last bit fall, withhold acknowledge
                    sw_trig     = 1'b1;
                    next_state  = pdrc_pkg::ST_WAIT;
                    next_sda_oe = 1'b0;
                  end else if (pointer == pdrc_pkg::PTR_PD_REF) begin
                    wr_strobe = 1'b1;
                  end
                end
              endcase
            end
          end
        end
        pdrc_pkg::ST_ACK: begin
          // Release after acknowledge, start sending on a read
          if (scl_fall) begin
            if (rw && byte_idx == 2'h0) begin
              next_state  = pdrc_pkg::ST_TX;
              next_sda_oe = ~tx_byte[7];
            end else begin
              next_state  = pdrc_pkg::ST_RX;
              next_sda_oe = 1'b0;
            end
          end
        end
        pdrc_pkg::ST_TX: begin
          // Shift out on each falling clock
          if (scl_fall) begin
            if (bit_cnt == 4'h7) begin
              next_bit_cnt = 4'h0;
              next_sda_oe  = 1'b0;
              next_state   = pdrc_pkg::ST_RACK;
            end else begin
              next_bit_cnt = bit_cnt + 4'h1;
              next_sda_oe  = ~tx_byte[3'(3'h6 - bit_cnt[2:0])];
            end
          end
        end
        pdrc_pkg::ST_RACK: begin
          // Host not acknowledging ends the read
          if (scl_rise && sda_i) begin
            next_state = pdrc_pkg::ST_WAIT;
          end else if (scl_fall) begin
            next_rd_sel = ~rd_sel;
            next_state  = pdrc_pkg::ST_TX;
            next_sda_oe = ~tx_next[7];
          end
        end
        pdrc_pkg::ST_WAIT: begin
          next_sda_oe = 1'b0;
        end
        default: begin
          next_state  = pdrc_pkg::ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Power control next state
  // ****************************************************************
  // Register contents, defaults while resetting
  always_comb begin
    next_pd_reg = pd_reg;
    if (sw_trig || pin_fall || busy) begin
      next_pd_reg = pdrc_pkg::PD_REG_RESET;
    end else if (wr_strobe) begin
      next_pd_reg = {msb[2:0], shreg};
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Link, register and output flip-flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state                  <= pdrc_pkg::ST_IDLE;
      bit_cnt                <= 4'h0;
      shreg                  <= 8'h00;
      byte_idx               <= 2'h0;
      rw                     <= 1'b0;
      rd_sel                 <= 1'b0;
      pointer                <= 8'h00;
      msb                    <= 8'h00;
      sda_oe                 <= 1'b0;
      sda_o                  <= 1'b0;
      pd_reg                 <= pdrc_pkg::PD_REG_RESET;
      scl_q                  <= 1'b1;
      sda_q                  <= 1'b1;
      pin_q                  <= 1'b1;
      dac_output_enable      <= 8'h00;
      dac_channel_power_down <= 8'h00;
      ref_enable             <= 1'b0;
      adc_power              <= 1'b0;
      config_reset           <= 1'b0;
    end else begin
      state    <= next_state;
      bit_cnt  <= next_bit_cnt;
      shreg    <= next_shreg;
      byte_idx <= next_byte_idx;
      rw       <= next_rw;
      rd_sel   <= next_rd_sel;
      pointer  <= next_pointer;
      msb      <= next_msb;
      sda_oe   <= next_sda_oe;
      sda_o    <= 1'b0;
      pd_reg   <= next_pd_reg;
      scl_q    <= scl;
      sda_q    <= sda_i;
      pin_q    <= reset_pin_n;
      // Channel down only when it is a DAC
      dac_channel_power_down <= dac_config & (pd_reg[pdrc_pkg::CH_MSB:0] | {8{gpd}});
      // Driver off when down; data kept elsewhere returns
      dac_output_enable <= dac_config & ~pd_reg[pdrc_pkg::CH_MSB:0] & {8{~gpd}};
      ref_enable <= pd_reg[pdrc_pkg::REF_BIT] & ~gpd;
      adc_power  <= ~gpd & ((|adc_config) | temp_read_active);
      config_reset <= sw_trig | pin_fall | busy;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_reset_hold;
    config_reset [*8];
  endsequence

  sequence s_no_ack;
    !sda_oe [*4];
  endsequence

  a_gpd_override: assert property (gpd |=> (dac_output_enable == 8'h00) && !ref_enable && !adc_power)
    else $error("global power-down did not override");
  a_dac_tristate: assert property (1'b1 |=> (dac_output_enable & $past(pd_reg[7:0])) == 8'h00)
    else $error("powered-down channel still driven");
  a_ref_follow: assert property (1'b1 |=> ref_enable == $past(pd_reg[9] & ~pd_reg[10]))
    else $error("reference enable mismatch");
  a_adc_auto_off: assert property ((adc_config == 8'h00) && !temp_read_active |=> !adc_power)
    else $error("adc powered with no adc pin");
  a_adc_temp_on: assert property (temp_read_active && !gpd |=> adc_power)
    else $error("adc not powered for temperature read");
  a_key_reset: assert property (sw_trig |=> s_reset_hold and (pd_reg == 11'h000))
    else $error("keyed write did not reset");
  a_key_no_ack: assert property (sw_trig |=> s_no_ack)
    else $error("keyed write acknowledged");
  a_pin_reset: assert property (pin_fall |=> config_reset ##1 (pd_reg == 11'h000))
    else $error("reset pin edge ignored");
  a_busy_refuse: assert property (busy |=> pd_reg == 11'h000 && !wr_strobe)
    else $error("register changed during reset");
  a_reg_write: assert property (wr_strobe && !busy |=> pd_reg == $past({msb[2:0], shreg}))
    else $error("register write lost");

endmodule // pdrc_ctrl

// >>> test/pdrc_host.sv
`timescale 1ns/1ps
// ****************************************************************
// Serial host model: open-drain data, pull-up on the data line
// ****************************************************************
module pdrc_host (
  input  wire logic clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic drv; // Host data level, 1 = released

  // Wired-AND of both parties; the pull-up wins when nobody pulls low
  assign sda = drv & ~sda_oe;

  // Bus idles high
  initial begin
    scl = 1'b1;
    drv = 1'b1;
  end

  // Wait a number of falling clock edges
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Start condition: data falls while the clock is high
  task automatic start_c;
    drv = 1'b1;
    scl = 1'b1;
    tick(8);
    drv = 1'b0;
    tick(8);
    scl = 1'b0;
    tick(4);
  endtask

  // Stop condition: data rises while the clock is high
  task automatic stop_c;
    drv = 1'b0;
    tick(8);
    scl = 1'b1;
    tick(8);
    drv = 1'b1;
    tick(8);
  endtask

  // One bit; data only moves well after the clock has fallen
  task automatic bit_io(input logic b, output logic got);
    drv = b;
    tick(8);
    scl = 1'b1;
    tick(8);
    got = sda;
    scl = 1'b0;
    tick(4);
  endtask

  // Byte out, most significant bit first; returns the acknowledge
  task automatic put(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(b[i], g);
    bit_io(1'b1, g);
    ack = ~g;
  endtask

  // Byte in; last = 1 sends the closing not-acknowledge
  task automatic get(input logic last, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, g);
      b[i] = g;
    end
    bit_io(last, g);
  endtask
endmodule // pdrc_host

// >>> test/pdrc_ctrl_bench.sv
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench for the power-down and reset control block
// ****************************************************************
module pdrc_ctrl_bench;
  localparam int unsigned RSTC = 600;                          // Shortened reset interval
  localparam logic [7:0]  AW   = {pdrc_pkg::DEV_ADDR_DEFAULT, 1'b0}; // Address, write
  logic       clk, rst_n, reset_pin_n, temp_read_active;       // Driven inputs
  logic       scl, sda, sda_o, sda_oe;                         // Serial link
  logic       ref_enable, adc_power, config_reset;             // Power outputs
  logic [7:0] dac_config, adc_config;                          // Pin configuration
  logic [7:0] dac_output_enable, dac_channel_power_down;       // Channel outputs
  int         num_errors, cmp_count;                           // Report counters

  pdrc_ctrl #(.RST_CYCLES(RSTC)) i_pdrc_ctrl (.clk(clk), .rst_n(rst_n), .scl(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .reset_pin_n(reset_pin_n),
    .dac_config(dac_config), .adc_config(adc_config), .temp_read_active(temp_read_active),
    .dac_output_enable(dac_output_enable), .dac_channel_power_down(dac_channel_power_down),
    .ref_enable(ref_enable), .adc_power(adc_power), .config_reset(config_reset));
  pdrc_host i_pdrc_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Closing report
  task automatic give_verdict;
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Full write: pointer, MSB, LSB; ah = all early acks, al = last ack
  task automatic wr_reg(input logic [7:0] p, input logic [15:0] d, output logic ah, al);
    logic a0, a1, a2;
    i_pdrc_host.start_c();
    i_pdrc_host.put(AW, a0);
    i_pdrc_host.put(p, a1);
    i_pdrc_host.put(d[15:8], a2);
    i_pdrc_host.put(d[7:0], al);
    i_pdrc_host.stop_c();
    ah = a0 & a1 & a2;
  endtask

  // Pointer-only write, then a two-byte read
  task automatic rd_reg(input logic [7:0] p, output logic [15:0] d);
    logic a;
    i_pdrc_host.start_c();
    i_pdrc_host.put(AW, a);
    i_pdrc_host.put(p, a);
    i_pdrc_host.stop_c();
    i_pdrc_host.start_c();
    i_pdrc_host.put(AW | 8'h01, a);
    i_pdrc_host.get(1'b0, d[15:8]);
    i_pdrc_host.get(1'b1, d[7:0]);
    i_pdrc_host.stop_c();
  endtask

  // Expected power outputs from a register value and the pin inputs
  task automatic check_outs(input logic [15:0] r);
    logic g;
    g = r[pdrc_pkg::GPD_BIT];
    repeat (3) @(negedge clk);
    check({8'h00, dac_output_enable}, {8'h00, dac_config & ~r[7:0] & {8{~g}}});
    check({8'h00, dac_channel_power_down}, {8'h00, dac_config & (r[7:0] | {8{g}})});
    check({15'h0000, ref_enable}, {15'h0000, r[pdrc_pkg::REF_BIT] & ~g});
    check({15'h0000, adc_power}, {15'h0000, ~g & (|adc_config | temp_read_active)});
    // Open-drain data value never leaves low
    check({15'h0000, sda_o}, 16'h0000);
  endtask

  // Write the power register, read it back, check outputs
  task automatic wr_chk(input logic [15:0] v);
    logic ah, al;
    logic [15:0] rd;
    wr_reg(pdrc_pkg::PTR_PD_REF, v, ah, al);
    check({14'h0000, ah, al}, 16'h0003);
    rd_reg(pdrc_pkg::PTR_PD_REF, rd);
    check(rd, v);
    check_outs(v);
  endtask

  // Bounded wait for the reset interval to end, then a short guard
  task automatic wait_done;
    int n;
    for (n = 0; n < 2000 && config_reset !== 1'b0; n++) @(negedge clk);
    if (n == 2000) begin
      num_errors++;
      give_verdict();
    end
    repeat (4) @(negedge clk);
  endtask

  // Defaults after reset, channel gating, restore, global override
  task automatic t_power;
    logic [15:0] rd;
    check_outs(16'h0000);
    check({15'h0000, config_reset}, 16'h0000);
    dac_config = 8'h5A;
    wr_chk(16'h02C3);
    dac_config = 8'hFF;
    check_outs(16'h02C3);
    wr_chk(16'h0000);
    adc_config = 8'h10;
    temp_read_active = 1'b1;
    wr_chk(16'h06FF);
    wr_chk(16'h0200);
    rd_reg(8'h0C, rd);
    check(rd, 16'h0000);
  endtask

  // No pin, temperature only, pin 7 only and pin 0 only for the converter supply
  task automatic t_adc;
    logic [8:0] tab [4];
    tab = '{9'h000, 9'h100, 9'h080, 9'h001};
    wr_chk(16'h0000);
    foreach (tab[k]) begin
      temp_read_active = tab[k][8];
      adc_config = tab[k][7:0];
      check_outs(16'h0000);
    end
  endtask

  // Wrong key does nothing, right key resets and refuses traffic
  task automatic t_key;
    logic ah, al, a;
    logic [15:0] rd;
    wr_chk(16'h02A5);
    wr_reg(pdrc_pkg::PTR_SW_RESET, 16'h0DAB, ah, al);
    check({14'h0000, ah, al, config_reset}, 16'h0006);
    check_outs(16'h02A5);
    wr_reg(pdrc_pkg::PTR_SW_RESET, pdrc_pkg::RESET_KEY, ah, al);
    check({14'h0000, ah, al}, 16'h0002);
    check({15'h0000, config_reset}, 16'h0001);
    check_outs(16'h0000);
    i_pdrc_host.start_c();
    i_pdrc_host.put(AW, a);
    i_pdrc_host.stop_c();
    check({15'h0000, a}, 16'h0000);
    wait_done();
    check_outs(16'h0000);
    rd_reg(pdrc_pkg::PTR_PD_REF, rd);
    check(rd, 16'h0000);
  endtask

  // Falling edge on the reset pin
  task automatic t_pin;
    logic [15:0] rd;
    wr_chk(16'h0201);
    reset_pin_n = 1'b0;
    repeat (3) @(negedge clk);
    check({15'h0000, config_reset}, 16'h0001);
    check_outs(16'h0000);
    reset_pin_n = 1'b1;
    wait_done();
    rd_reg(pdrc_pkg::PTR_PD_REF, rd);
    check(rd, 16'h0000);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    reset_pin_n = 1'b1;
    dac_config = 8'hFF;
    adc_config = 8'h00;
    temp_read_active = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_power();
    t_adc();
    t_key();
    t_pin();
    give_verdict();
  end
endmodule // pdrc_ctrl_bench
